/* File: hdl/atf_task_file.sv */
// Purpose: Status, control and command decode of the task file
// Assumes: Media engine reports through atf_media_t
// Notes:   Register reads answer one cycle after the strobe
`timescale 1ns/100ps
`include "atf_defs.svh"

module atf_task_file (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  output logic [7:0]              reg_rdata_oe,
  input  wire logic               mem_mode,
  input  wire logic               drive_id,
  output logic                    cmd_start,
  output atf_pkg::atf_cmd_t       cmd_ff,
  input  wire atf_pkg::atf_media_t media,
  output logic                    host_interrupt_request,
  output logic                    host_interrupt_request_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  atf_pkg::atf_state_t state_ff;
  logic [7:0]  status_ff;
  logic [7:0]  drvhead_ff;
  logic [7:0]  seccnt_ff;
  logic [7:0]  error_ff;
  logic        irq_disable_bit_ff;
  logic        irq_ff;
  logic        hold_ready_ff;
  logic [7:0]  soft_reset_bit_cnt_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  rdoe_ff;
  logic        nxt_ready;

  logic wr_cmd;
  logic wr_ctl;
  logic rd_status;
  logic selected;
  logic soft_reset_bit_req;
  atf_pkg::atf_cmd_t nxt_cmd;

  assign wr_cmd    = reg_wr && reg_addr == `ATF_A_COMMAND && state_ff == atf_pkg::ATF_IDLE;
  assign wr_ctl    = reg_wr && reg_addr == `ATF_A_DEVCTL;
  assign rd_status = reg_rd && reg_addr == `ATF_A_STATUS;
  assign selected  = drvhead_ff[`ATF_B_DRV] == drive_id;
  assign soft_reset_bit_req  = wr_ctl && reg_wdata[`ATF_B_SOFT_RESET_BIT];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cmd            = '0;
    nxt_cmd.op         = reg_wdata;
    nxt_cmd.erase      = 1'b1;
    nxt_cmd.retry      = 1'b1;
    nxt_cmd.sectors    = (seccnt_ff == 8'h00) ? 9'h100 : {1'b0, seccnt_ff};
    nxt_cmd.all_drives = reg_wdata == `ATF_C_DIAG;
    unique case (reg_wdata)
      `ATF_C_RD_RETRY:    nxt_cmd.read = 1'b1;
      `ATF_C_RD_NORETRY: begin
        nxt_cmd.read  = 1'b1;
        nxt_cmd.retry = 1'b0;
      end
      `ATF_C_RDM:         nxt_cmd.read = 1'b1;
      `ATF_C_WR_RETRY,
      `ATF_C_WRM:         nxt_cmd.write = 1'b1;
      `ATF_C_WR_NORETRY: begin
        nxt_cmd.write = 1'b1;
        nxt_cmd.retry = 1'b0;
      end
      `ATF_C_WRM_NOERASE,
      `ATF_C_WR_NOERASE: begin
        nxt_cmd.write = 1'b1;
        nxt_cmd.erase = 1'b0;
      end
      default: nxt_cmd.op = reg_wdata;
    endcase
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= atf_pkg::ATF_IDLE;
      soft_reset_bit_cnt_ff <= 8'h00;
    end else if (soft_reset_bit_req) begin
      state_ff    <= atf_pkg::ATF_SOFT_RESET_BIT;
      soft_reset_bit_cnt_ff <= 8'(`ATF_SOFT_RESET_BIT_CYC);
    end else begin
      unique case (state_ff)
        atf_pkg::ATF_IDLE: begin
          if (wr_cmd && (selected || nxt_cmd.all_drives)) begin
            state_ff <= atf_pkg::ATF_RUN;
          end
        end
        atf_pkg::ATF_RUN: begin
          if (media.done) begin
            state_ff <= atf_pkg::ATF_IDLE;
          end
        end
        atf_pkg::ATF_SOFT_RESET_BIT: begin
          if (soft_reset_bit_cnt_ff == 8'h01) begin
            state_ff <= atf_pkg::ATF_IDLE;
          end
          soft_reset_bit_cnt_ff <= soft_reset_bit_cnt_ff - 8'h01;
        end
      endcase
    end
  end

  assign cmd_start = state_ff == atf_pkg::ATF_IDLE && wr_cmd && (selected || nxt_cmd.all_drives);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_ff <= '0;
    end else if (cmd_start) begin
      cmd_ff <= nxt_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Task file registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drvhead_ff <= 8'ha0;
      seccnt_ff  <= 8'h01;
      irq_disable_bit_ff    <= 1'b0;
    end else if (state_ff == atf_pkg::ATF_SOFT_RESET_BIT && soft_reset_bit_cnt_ff == 8'h01) begin
      drvhead_ff <= 8'ha0;
      seccnt_ff  <= 8'h01;
    end else if (reg_wr) begin
      if (reg_addr == `ATF_A_DRVHEAD) drvhead_ff <= reg_wdata;
      if (reg_addr == `ATF_A_SECCNT) seccnt_ff <= reg_wdata;
      if (reg_addr == `ATF_A_DEVCTL) irq_disable_bit_ff <= reg_wdata[`ATF_B_IRQ_DISABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ready = status_ff[`ATF_B_READY];
    if (!hold_ready_ff) begin
      nxt_ready = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_ff     <= 8'h00;
      error_ff      <= 8'h00;
      hold_ready_ff <= 1'b0;
    end else if (soft_reset_bit_req || state_ff == atf_pkg::ATF_SOFT_RESET_BIT) begin
      status_ff     <= 8'h80;
      hold_ready_ff <= 1'b0;
      if (state_ff == atf_pkg::ATF_SOFT_RESET_BIT && soft_reset_bit_cnt_ff == 8'h01) begin
        status_ff <= 8'h50;
        error_ff  <= 8'h00;
      end
    end else if (cmd_start) begin
      status_ff                <= status_ff;
      status_ff[`ATF_B_BUSY]   <= 1'b1;
      status_ff[`ATF_B_WFAULT] <= 1'b0;
      status_ff[`ATF_B_FIXED]  <= 1'b0;
      status_ff[`ATF_B_FAIL]   <= 1'b0;
      error_ff                 <= 8'h00;
    end else if (state_ff == atf_pkg::ATF_RUN) begin
      status_ff[`ATF_B_WFAULT] <= status_ff[`ATF_B_WFAULT] | media.write_fault;
      status_ff[`ATF_B_SEEK]   <= media.seek_done;
      status_ff[`ATF_B_DREQ]   <= media.data_req;
      status_ff[`ATF_B_FIXED]  <= status_ff[`ATF_B_FIXED] | media.corrected;
      status_ff[1]             <= 1'b0;
      if (media.done) begin
        status_ff[`ATF_B_BUSY] <= 1'b0;
        status_ff[`ATF_B_DREQ] <= 1'b0;
        status_ff[`ATF_B_FAIL] <= media.fail;
        hold_ready_ff          <= media.fail;
        if (media.fail) error_ff <= (media.cause == 8'h00) ? `ATF_ERR_ABORT : media.cause;
      end
    end else begin
      if (rd_status) hold_ready_ff <= 1'b0;
      status_ff[`ATF_B_READY] <= nxt_ready;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else if (state_ff == atf_pkg::ATF_RUN && media.done) begin
      irq_ff <= 1'b1;
    end else if (rd_status || soft_reset_bit_req) begin
      irq_ff <= 1'b0;
    end
  end

  assign host_interrupt_request    = ~irq_ff;
  assign host_interrupt_request_oe = mem_mode || (!irq_disable_bit_ff && selected);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
      rdoe_ff  <= 8'h00;
    end else if (reg_rd) begin
      rdoe_ff <= 8'hff;
      unique case (reg_addr)
        `ATF_A_STATUS,
        `ATF_A_SHADOW:  rdata_ff <= status_ff;
        `ATF_A_DRVADDR: begin
          rdata_ff <= {1'b0, 1'b1, ~drvhead_ff[3:0],
                       ~(selected && drive_id), ~(selected && !drive_id)};
          rdoe_ff  <= 8'h7f;
        end
        `ATF_A_DRVHEAD: rdata_ff <= drvhead_ff;
        `ATF_A_SECCNT:  rdata_ff <= seccnt_ff;
        `ATF_A_ERROR:   rdata_ff <= error_ff;
        default:        rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
      rdoe_ff  <= 8'h00;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign reg_rdata_oe = rdoe_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_status_clears_irq;
    @(posedge mclk) disable iff (!rstn)
      rd_status && !(state_ff == atf_pkg::ATF_RUN && media.done) |=> !irq_ff;
  endproperty
  a_status_clears_irq: assert property (p_status_clears_irq) else $error("status read kept irq");

  property p_shadow_keeps_irq;
    @(posedge mclk) disable iff (!rstn)
      reg_rd && reg_addr == `ATF_A_SHADOW && irq_ff && !soft_reset_bit_req |=> irq_ff && rdata_ff == $past(status_ff);
  endproperty
  a_shadow_keeps_irq: assert property (p_shadow_keeps_irq) else $error("shadow read wrong");

  property p_start_busy;
    @(posedge mclk) disable iff (!rstn)
      cmd_start && !soft_reset_bit_req |=> status_ff[`ATF_B_BUSY];
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set");

  property p_ready_held;
    @(posedge mclk) disable iff (!rstn)
      hold_ready_ff && !rd_status && !soft_reset_bit_req && state_ff == atf_pkg::ATF_IDLE |=> $stable(status_ff[`ATF_B_READY]);
  endproperty
  a_ready_held: assert property (p_ready_held) else $error("ready moved before status read");

  property p_index_zero;
    @(posedge mclk) disable iff (!rstn)
      reg_rd |=> !rdata_ff[1] || $past(reg_addr) != `ATF_A_STATUS;
  endproperty
  a_index_zero: assert property (p_index_zero) else $error("index bit set");

  property p_sector_256;
    @(posedge mclk) disable iff (!rstn)
      cmd_start && seccnt_ff == 8'h00 && !soft_reset_bit_req |=> cmd_ff.sectors == 9'h100;
  endproperty
  a_sector_256: assert property (p_sector_256) else $error("zero count not 256");

  property p_noerase;
    @(posedge mclk) disable iff (!rstn)
      cmd_start && reg_wdata == `ATF_C_WR_NOERASE |=> !cmd_ff.erase && cmd_ff.write;
  endproperty
  a_noerase: assert property (p_noerase) else $error("erase not skipped");

  property p_soft_reset_bit_busy;
    @(posedge mclk) disable iff (!rstn)
      soft_reset_bit_req |=> status_ff[`ATF_B_BUSY] [*8];
  endproperty
  a_soft_reset_bit_busy: assert property (p_soft_reset_bit_busy) else $error("busy dropped in reset");

  property p_drvaddr_heads;
    @(posedge mclk) disable iff (!rstn)
      reg_rd && reg_addr == `ATF_A_DRVADDR |=> rdata_ff[5:2] == ~$past(drvhead_ff[3:0]) && !rdoe_ff[7];
  endproperty
  a_drvaddr_heads: assert property (p_drvaddr_heads) else $error("drive address wrong");

  property p_wfault_set;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_RUN && media.write_fault && !soft_reset_bit_req |=> status_ff[`ATF_B_WFAULT];
  endproperty
  a_wfault_set: assert property (p_wfault_set) else $error("write fault not set");

  property p_seek_set;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_RUN && media.seek_done && !soft_reset_bit_req |=> status_ff[`ATF_B_SEEK];
  endproperty
  a_seek_set: assert property (p_seek_set) else $error("seek complete not set");

  property p_dreq_follow;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_RUN && !media.done && !soft_reset_bit_req |=> status_ff[`ATF_B_DREQ] == $past(media.data_req);
  endproperty
  a_dreq_follow: assert property (p_dreq_follow) else $error("data request wrong");

  property p_fixed_set;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_RUN && media.corrected && !soft_reset_bit_req |=> status_ff[`ATF_B_FIXED];
  endproperty
  a_fixed_set: assert property (p_fixed_set) else $error("fixed data not set");

  property p_fail_flag;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_RUN && media.done && !soft_reset_bit_req |=>
        !status_ff[`ATF_B_BUSY] && status_ff[`ATF_B_FAIL] == $past(media.fail);
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("error bit wrong at end");

  property p_irq_float;
    @(posedge mclk) disable iff (!rstn)
      !mem_mode && (irq_disable_bit_ff || drvhead_ff[`ATF_B_DRV] != drive_id) |-> !host_interrupt_request_oe;
  endproperty
  a_irq_float: assert property (p_irq_float) else $error("interrupt pin driven while gated");

  property p_mem_mode_drive;
    @(posedge mclk) disable iff (!rstn)
      mem_mode |-> host_interrupt_request_oe;
  endproperty
  a_mem_mode_drive: assert property (p_mem_mode_drive) else $error("interrupt pin gated in memory mode");

  property p_read_retry;
    @(posedge mclk) disable iff (!rstn)
      cmd_start && (reg_wdata == `ATF_C_RD_RETRY || reg_wdata == `ATF_C_RD_NORETRY) |=>
        cmd_ff.read && cmd_ff.retry == !$past(reg_wdata[0]);
  endproperty
  a_read_retry: assert property (p_read_retry) else $error("retry pair decoded wrong");

  property p_diag_any_drive;
    @(posedge mclk) disable iff (!rstn)
      wr_cmd && reg_wdata == `ATF_C_DIAG |-> cmd_start;
  endproperty
  a_diag_any_drive: assert property (p_diag_any_drive) else $error("diagnostic refused");

  property p_soft_reset_bit_idle;
    @(posedge mclk) disable iff (!rstn)
      state_ff == atf_pkg::ATF_SOFT_RESET_BIT && soft_reset_bit_cnt_ff == 8'h01 && !soft_reset_bit_req |=>
        state_ff == atf_pkg::ATF_IDLE && status_ff == 8'h50 && drvhead_ff == 8'ha0 && error_ff == 8'h00;
  endproperty
  a_soft_reset_bit_idle: assert property (p_soft_reset_bit_idle) else $error("soft reset end wrong");

endmodule

/* File: hdl/atf_defs.svh */
// Purpose: Constants for the task file status, control and command decode block
// Assumes: Plain register port, one 25 MHz clock
// Notes:   Offsets are byte indexes on the register port
`ifndef ATF_DEFS_SVH
`define ATF_DEFS_SVH

`define ATF_A_STATUS      3'h0
`define ATF_A_SHADOW      3'h1
`define ATF_A_COMMAND     3'h2
`define ATF_A_DEVCTL      3'h3
`define ATF_A_DRVADDR     3'h4
`define ATF_A_DRVHEAD     3'h5
`define ATF_A_SECCNT      3'h6
`define ATF_A_ERROR       3'h7

`define ATF_B_BUSY        7
`define ATF_B_READY       6
`define ATF_B_WFAULT      5
`define ATF_B_SEEK        4
`define ATF_B_DREQ        3
`define ATF_B_FIXED       2
`define ATF_B_FAIL        0
`define ATF_B_SOFT_RESET_BIT        2
`define ATF_B_IRQ_DISABLE_BIT        1
`define ATF_B_DRV         4

`define ATF_C_DIAG        8'h90
`define ATF_C_RD_RETRY    8'h20
`define ATF_C_RD_NORETRY  8'h21
`define ATF_C_WR_RETRY    8'h30
`define ATF_C_WR_NORETRY  8'h31
`define ATF_C_WRM_NOERASE 8'hcd
`define ATF_C_WR_NOERASE  8'h38
`define ATF_C_WRM         8'hc5
`define ATF_C_RDM         8'hc4

`define ATF_SOFT_RESET_BIT_NS       2000
`define ATF_CLK_NS        40
`define ATF_SOFT_RESET_BIT_CYC      ((`ATF_SOFT_RESET_BIT_NS + `ATF_CLK_NS - 1) / `ATF_CLK_NS)
`define ATF_ERR_ABORT     8'h04

`endif

/* File: hdl/atf_pkg.sv */
// Purpose: Types for the task file block
// Assumes: Used with atf_defs.svh
// Notes:   Nothing here is imported
package atf_pkg;
  typedef enum logic [1:0] {ATF_IDLE, ATF_RUN, ATF_SOFT_RESET_BIT} atf_state_t;

  typedef struct packed {
    logic [7:0] op;
    logic       read;
    logic       write;
    logic       retry;
    logic       erase;
    logic       all_drives;
    logic [8:0] sectors;
  } atf_cmd_t;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic [7:0] cause;
    logic       write_fault;
    logic       seek_done;
    logic       corrected;
    logic       data_req;
  } atf_media_t;
endpackage

/* File: tb/atf_media_model.sv */
// Purpose: Media engine stand-in for the task file bench
// Assumes: One clock; cmd_start starts an operation
// Notes:   Delay and fault come from the bench
`timescale 1ns/100ps
module atf_media_model (
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire logic           cmd_start,
  input  wire logic [7:0]     dly,
  input  wire logic           fail_req,
  input  wire logic [7:0]     cause_req,
  input  wire logic [2:0]     flag_req,
  output atf_pkg::atf_media_t media
);
  logic [7:0] cnt_ff;
  // ----------------------------------------
  // Operation timer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
    end else if (cmd_start) begin
      cnt_ff <= dly;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  always_comb begin
    media           = '0;
    media.done      = (cnt_ff == 8'h01);
    media.fail      = media.done & fail_req;
    media.cause     = media.done ? cause_req : ~cause_req;
    media.seek_done = 1'b1;
    media.write_fault = flag_req[2];
    media.corrected   = flag_req[1];
    media.data_req    = flag_req[0] & (cnt_ff != 8'h00);
  end
endmodule

/* File: tb/tb_ata_task_file_status_control.sv */
// Purpose: Self-checking bench of the task file block
// Assumes: Register indexes 0 status .. 7 error
// Notes:   Expected values worked out here
`timescale 1ns/100ps
module tb_ata_task_file_status_control;
  logic                mclk, rstn, reg_wr, reg_rd, mem_mode, drive_id;
  logic                cmd_start, irq_n, irq_oe, fail_req, started;
  logic [2:0]          reg_addr, flag_req;
  logic [7:0]          reg_wdata, reg_rdata, reg_rdata_oe, dly, cause_req, rv, ro, cnt;
  atf_pkg::atf_cmd_t   cmd_ff;
  atf_pkg::atf_media_t media;
  int                  err_count, comparisons, seed, i, k, h;
  logic [15:0]         tbl[6] = '{16'h20ae, 16'h218e, 16'h307f, 16'h315f, 16'h384d, 16'hcd4d};

  atf_task_file dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_oe(reg_rdata_oe),
    .mem_mode(mem_mode), .drive_id(drive_id), .cmd_start(cmd_start), .cmd_ff(cmd_ff),
    .media(media), .host_interrupt_request(irq_n), .host_interrupt_request_oe(irq_oe));
  atf_media_model far (.mclk(mclk), .rstn(rstn), .cmd_start(cmd_start), .dly(dly),
    .fail_req(fail_req), .cause_req(cause_req), .flag_req(flag_req), .media(media));

  always #20 mclk = ~mclk;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input logic [8:0] m);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    #1 started = cmd_start;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    ro = reg_rdata_oe;
  endtask
  task automatic wait_done();
    for (k = 0; k < 300 && media.done !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk(9'(media.done), 9'h001, 9'h001);
    @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'h2724;
    {mclk, rstn, reg_wr, reg_rd, mem_mode, drive_id, fail_req} = '0;
    {reg_addr, reg_wdata, cause_req, flag_req} = '0;
    dly = 8'h04;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(0);
    chk(9'(rv), 9'h000, 9'h082);
    rd(4);
    chk(9'(rv), 9'h07e, 9'h07f);
    chk(9'(ro), 9'h07f, 9'h0ff);
    $display("Test reset done");
    h = $random(seed) & 15;
    wr(5, 8'ha0 | 8'(h));
    rd(4);
    chk(9'(rv), 9'h042 | 9'((~h & 15) << 2), 9'h07f);
    $display("Test drive address done");
    wr(3, 8'h08);
    for (i = 0; i < 6; i++) begin
      cnt = (i == 0) ? 8'h00 : 8'($random(seed));
      dly <= 8'd4 + 8'($random(seed) & 31);
      flag_req <= 3'($random(seed));
      wr(5, 8'ha0);
      wr(6, cnt);
      wr(2, tbl[i][15:8]);
      chk(9'(started), 9'h001, 9'h001);
      chk(9'({cmd_ff.read, cmd_ff.write, cmd_ff.retry, cmd_ff.erase}), 9'(tbl[i][7:4]),
          9'(tbl[i][3:0]));
      chk(cmd_ff.sectors, (cnt == 8'h00) ? 9'h100 : 9'(cnt), 9'h1ff);
      rd(0);
      chk(9'(rv), 9'h080 | (9'(flag_req[0]) << 3), 9'h088);
      wait_done();
      chk(9'({irq_n, irq_oe}), 9'h001, 9'h003);
      rd(1);
      chk(9'({irq_n, rv}), 9'h050 | (9'(flag_req[2]) << 5) | (9'(flag_req[1]) << 2), 9'h1ff);
      rd(0);
      chk(9'({irq_n, rv}), 9'h150 | (9'(flag_req[2]) << 5) | (9'(flag_req[1]) << 2), 9'h1ff);
    end
    $display("Test command codes done");
    fail_req  <= 1'b1;
    cause_req <= 8'h10;
    wr(2, 8'h30);
    wait_done();
    fail_req <= 1'b0;
    rd(1);
    chk(9'(rv), 9'h001, 9'h081);
    rd(7);
    chk(9'(rv), 9'h010, 9'h0ff);
    rd(0);
    chk(9'(rv), 9'h001, 9'h081);
    $display("Test error done");
    wr(5, 8'hb0);
    wr(2, 8'h20);
    chk(9'(started), 9'h000, 9'h001);
    wr(2, 8'h90);
    chk(9'(started), 9'h001, 9'h001);
    chk(9'(cmd_ff.all_drives), 9'h001, 9'h001);
    wait_done();
    chk(9'(irq_oe), 9'h000, 9'h001);
    mem_mode <= 1'b1;
    @(posedge mclk);
    #1 chk(9'(irq_oe), 9'h001, 9'h001);
    mem_mode <= 1'b0;
    wr(5, 8'ha0);
    wr(3, 8'h0a);
    chk(9'(irq_oe), 9'h000, 9'h001);
    mem_mode <= 1'b1;
    @(posedge mclk);
    #1 chk(9'(irq_oe), 9'h001, 9'h001);
    mem_mode <= 1'b0;
    rd(0);
    $display("Test interrupt gating done");
    wr(5, 8'ha7);
    wr(3, 8'hfc);
    wr(3, 8'h08);
    rd(0);
    chk(9'(rv), 9'h080, 9'h080);
    repeat (60) @(posedge mclk);
    rd(0);
    chk(9'(rv), 9'h050, 9'h0ff);
    rd(4);
    chk(9'(rv), 9'h07e, 9'h07f);
    $display("Test soft reset done");
    report_and_stop();
  end
endmodule
